// >>> include/fault_pkg.sv
// Constants and carriers for the hardware fault shutdown path
package fault_pkg;

  // Geometry
  localparam int NUM_STAGES  = 6;  // Stages 1A 1B 2A 2B 3A 4A
  localparam int NUM_RAILS   = 4;
  localparam int RAIL_W      = 2;
  localparam int PHASE_CNT_W = 3;

  // Clock rate
  localparam int CLK_MHZ = 200;

  // Latency limits in their own units
  localparam int EXT_FAULT_BASE_US = 15;  // Pin fault to output off
  localparam int RAIL_OFF_BASE_US  = 10;  // Comparator fault to whole rail off
  localparam int PER_PHASE_US      = 3;   // Added per configured phase
  localparam int CMP_MAX_SW_CYCLES = 4;   // Comparator trip to first output off

  // Longest times in whole cycles, microseconds times CLK_MHZ
  localparam int EXT_FAULT_BASE_CYC = EXT_FAULT_BASE_US * CLK_MHZ;
  localparam int RAIL_OFF_BASE_CYC  = RAIL_OFF_BASE_US * CLK_MHZ;
  localparam int PER_PHASE_CYC      = PER_PHASE_US * CLK_MHZ;

  // Reset values
  localparam logic [NUM_STAGES-1:0] STAGES_CLEAR = 6'h00;
  localparam logic [NUM_RAILS-1:0]  RAILS_CLEAR  = 4'h0;
  localparam logic [2:0]            SYNC_CLEAR   = 3'h0;
  localparam logic [2:0]            SYNC_HIGH    = 3'h7;

  // Stage to rail assignment
  typedef logic [NUM_STAGES-1:0][RAIL_W-1:0] rail_map_type;

  // Three flip-flop synchroniser with its agreed value
  typedef struct packed {
    logic [NUM_STAGES-1:0] s1;
    logic [NUM_STAGES-1:0] s2;
    logic [NUM_STAGES-1:0] s3;
    logic [NUM_STAGES-1:0] agreed;
  } sync_vec_type;

  // Gate drive pair toward the power stages
  typedef struct packed {
    logic [NUM_STAGES-1:0] pwm_out;
    logic [NUM_STAGES-1:0] sync_rect_enable;
  } drive_type;

  // Whole state of the shutdown block
  typedef struct packed {
    sync_vec_type          ext;          // External fault pins
    sync_vec_type          cmp;          // Analog comparator trips
    logic [2:0]            rst_sync;     // Device reset pin, s1 s2 s3
    logic                  rst_agreed;   // Filtered reset pin level
    logic [NUM_STAGES-1:0] ext_latch;    // Stage held off by pin fault
    logic [NUM_STAGES-1:0] cmp_latch;    // Stage whose comparator tripped
    logic [NUM_RAILS-1:0]  rail_off;     // Rail held off by comparator fault
    drive_type             drive;        // Registered gate outputs
    logic [NUM_STAGES-1:0] stage_off;    // Registered shutdown status
  } state_type;

endpackage

// >>> hw/hw_fault_pwm_shutdown.sv
// Hardware fault shutdown path between PWM generator and gate drivers
`timescale 1ns/1ps

// Notes on behaviour
// R01 - A high external fault pin forces its PWM output off within 15 us + 3 us/phase.
// R02 - A comparator trip disables the first affected PWM output within four switch cycles.
// R03 - A comparator trip then disables every PWM and rectifier enable of that rail.
// R04 - Fault shutdown never waits on the ADC monitoring sequencer.
// R05 - External fault pins are asserted high and deasserted low.
// R06 - Each stage's current sense feeds measurement and the comparator of that stage.
// R07 - Device held in reset while the reset pin is low, released when high.
// R08 - Rectifier enable high enables the rectifier; shutdown drives it low.
// R09 - Faulted outputs stay off until fault response logic or reset re-enables the rail.
module hw_fault_pwm_shutdown (
  // Clock and reset
  input  wire logic                               ref_clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               device_reset_n_i,
  // Configuration
  input  wire logic [fault_pkg::PHASE_CNT_W-1:0]  phase_count_i,
  input  wire fault_pkg::rail_map_type            stage_rail_i,
  // Fault sources, asynchronous to the clock
  input  wire logic [fault_pkg::NUM_STAGES-1:0]   ext_fault_in_i,
  input  wire logic [fault_pkg::NUM_STAGES-1:0]   cmp_trip_i,
  // Current sense samples per stage
  input  wire logic [fault_pkg::NUM_STAGES-1:0]   cs_sample_i,
  // Re-enable requests from fault response logic, one bit per rail
  input  wire logic [fault_pkg::NUM_RAILS-1:0]    rail_reenable_i,
  // Raw drive from the PWM generator
  input  wire fault_pkg::drive_type               drive_in_i,
  // Gated drive toward the power stages
  output fault_pkg::drive_type                    drive_o,
  // Status
  output logic [fault_pkg::NUM_STAGES-1:0]        stage_off_o,
  output logic [fault_pkg::NUM_RAILS-1:0]         rail_off_o,
  output logic [fault_pkg::NUM_STAGES-1:0]        cs_meas_o,
  output logic [fault_pkg::NUM_STAGES-1:0]        cs_cmp_o,
  output logic                                    core_reset_o
);

  fault_pkg::state_type state_reg;
  fault_pkg::state_type state_next;

  // Combinational masks built from registered state and same-clock inputs
  logic [fault_pkg::NUM_STAGES-1:0] active_mask;  // Stages inside the phase count
  logic [fault_pkg::NUM_STAGES-1:0] reen_mask;    // Stages of rails being re-enabled
  logic [fault_pkg::NUM_RAILS-1:0]  trip_rails;   // Rails with an agreed comparator trip
  logic [fault_pkg::NUM_STAGES-1:0] rail_mask;    // Stages of rails held or going off
  logic [fault_pkg::NUM_STAGES-1:0] off_mask;     // Stages forced off on the next edge

  // Stages of one rail, used for both shutdown and re-enable
  function automatic logic [fault_pkg::NUM_STAGES-1:0] rail_stages(
    input fault_pkg::rail_map_type         map,
    input logic [fault_pkg::RAIL_W-1:0]    rail
  );
    logic [fault_pkg::NUM_STAGES-1:0] mask;
    mask = fault_pkg::STAGES_CLEAR;
    for (int s = 0; s < fault_pkg::NUM_STAGES; s++) begin
      mask[s] = (map[s] == rail);
    end
    return mask;
  endfunction

  // Stages beyond the configured phase count are never driven
  function automatic logic [fault_pkg::NUM_STAGES-1:0] active_stages(
    input logic [fault_pkg::PHASE_CNT_W-1:0] count
  );
    logic [fault_pkg::NUM_STAGES-1:0] mask;
    mask = fault_pkg::STAGES_CLEAR;
    for (int s = 0; s < fault_pkg::NUM_STAGES; s++) begin
      mask[s] = (s < int'(count));
    end
    return mask;
  endfunction

  // Stages of every rail set in a rail vector
  function automatic logic [fault_pkg::NUM_STAGES-1:0] stages_of_rails(
    input fault_pkg::rail_map_type         map,
    input logic [fault_pkg::NUM_RAILS-1:0] rails
  );
    logic [fault_pkg::NUM_STAGES-1:0] mask;
    mask = fault_pkg::STAGES_CLEAR;
    for (int r = 0; r < fault_pkg::NUM_RAILS; r++) begin
      if (rails[r]) begin
        mask = mask | rail_stages(map, fault_pkg::RAIL_W'(r));
      end
    end
    return mask;
  endfunction

  // Rails that hold at least one stage set in a stage vector
  function automatic logic [fault_pkg::NUM_RAILS-1:0] rails_of_stages(
    input fault_pkg::rail_map_type          map,
    input logic [fault_pkg::NUM_STAGES-1:0] stages
  );
    logic [fault_pkg::NUM_RAILS-1:0] rails;
    rails = fault_pkg::RAILS_CLEAR;
    for (int s = 0; s < fault_pkg::NUM_STAGES; s++) begin
      if (stages[s]) begin
        rails[map[s]] = 1'b1;
      end
    end
    return rails;
  endfunction

  // Agreed level of a synchronised vector: a bit moves once s2 and s3 match
  function automatic logic [fault_pkg::NUM_STAGES-1:0] sync_agree(
    input logic [fault_pkg::NUM_STAGES-1:0] s2,
    input logic [fault_pkg::NUM_STAGES-1:0] s3,
    input logic [fault_pkg::NUM_STAGES-1:0] agreed
  );
    logic [fault_pkg::NUM_STAGES-1:0] result;
    result = agreed;
    for (int s = 0; s < fault_pkg::NUM_STAGES; s++) begin
      if (s2[s] == s3[s]) begin
        result[s] = s3[s];
      end
    end
    return result;
  endfunction

  // Reset value of the whole state; the reset pin filter idles high like its pull-up
  function automatic fault_pkg::state_type reset_state();
    fault_pkg::state_type st;
    st.ext        = '0;
    st.cmp        = '0;
    st.rst_sync   = fault_pkg::SYNC_HIGH;
    st.rst_agreed = 1'b1;
    st.ext_latch  = fault_pkg::STAGES_CLEAR;
    st.cmp_latch  = fault_pkg::STAGES_CLEAR;
    st.rail_off   = fault_pkg::RAILS_CLEAR;
    st.drive      = '0;
    st.stage_off  = fault_pkg::STAGES_CLEAR;
    return st;
  endfunction

  // Current sense goes to measurement and to the same-numbered comparator
  for (genvar g = 0; g < fault_pkg::NUM_STAGES; g++) begin : g_cs_route
    assign cs_meas_o[g] = cs_sample_i[g];  // R06
    assign cs_cmp_o[g]  = cs_sample_i[g];  // R06
  end

  // Masks for gating; unconfigured stages are always off
  assign active_mask = active_stages(phase_count_i);
  assign reen_mask   = stages_of_rails(stage_rail_i, rail_reenable_i);  // R09
  assign trip_rails  = rails_of_stages(stage_rail_i, state_reg.cmp.agreed);  // R03
  assign rail_mask   = stages_of_rails(stage_rail_i, state_reg.rail_off | trip_rails);  // R03
  // A fresh agreed fault gates the drive on the same edge that latches it
  assign off_mask    = state_reg.ext_latch | state_reg.ext.agreed  // R01
                     | state_reg.cmp_latch | state_reg.cmp.agreed  // R02
                     | rail_mask | ~active_mask;

  // Timing of the shutdown path, in clock edges after a fault input changes:
  //   1-3  the level walks through the three synchroniser flops
  //   4    s2 and s3 agree and the agreed level updates
  //   5    the gated drive register turns the stage off
  // A comparator trip takes its whole rail down on the same edge, and the rail
  // latch sets on that same edge. At 5 ns a clock this is tens of nanoseconds,
  // far inside the microsecond shutdown limits for any phase count.
  // A pulse shorter than one clock never makes s2 and s3 agree and is dropped.
  // Next state of the whole block; nothing from the monitoring sequencer enters
  always_comb begin  // R04
    logic in_reset;
    in_reset   = 1'b0;
    state_next = state_reg;

    // Pin fault synchroniser: three flops, a change counts once s2 and s3 agree
    state_next.ext.s1     = ext_fault_in_i;
    state_next.ext.s2     = state_reg.ext.s1;
    state_next.ext.s3     = state_reg.ext.s2;
    state_next.ext.agreed = sync_agree(state_reg.ext.s2, state_reg.ext.s3,
                                       state_reg.ext.agreed);  // R05

    // Comparator trips pass the same filter
    state_next.cmp.s1     = cmp_trip_i;
    state_next.cmp.s2     = state_reg.cmp.s1;
    state_next.cmp.s3     = state_reg.cmp.s2;
    state_next.cmp.agreed = sync_agree(state_reg.cmp.s2, state_reg.cmp.s3,
                                       state_reg.cmp.agreed);  // R02

    // Reset pin filter; only the second flop feeds the third
    state_next.rst_sync = {state_reg.rst_sync[1:0], device_reset_n_i};
    if (state_reg.rst_sync[1] == state_reg.rst_sync[2]) begin
      state_next.rst_agreed = state_reg.rst_sync[2];
    end
    in_reset = !state_reg.rst_agreed;  // R07

    // Stage latches: a fault still agreed wins over a re-enable of its rail
    state_next.ext_latch = (state_reg.ext_latch & ~reen_mask) | state_reg.ext.agreed;  // R01 R09
    state_next.cmp_latch = (state_reg.cmp_latch & ~reen_mask) | state_reg.cmp.agreed;  // R02 R09

    // Rail latch: set by a trip of any of its stages, set wins over re-enable
    state_next.rail_off  = (state_reg.rail_off & ~rail_reenable_i) | trip_rails;  // R03 R09

    // Registered gate drive and status
    state_next.stage_off              = off_mask;
    state_next.drive.pwm_out          = drive_in_i.pwm_out & ~off_mask;  // R01 R02
    state_next.drive.sync_rect_enable = drive_in_i.sync_rect_enable & ~off_mask;  // R03 R08

    // Filtered reset pin low clears everything behind the synchronisers
    if (in_reset) begin  // R07
      state_next.ext_latch = fault_pkg::STAGES_CLEAR;
      state_next.cmp_latch = fault_pkg::STAGES_CLEAR;
      state_next.rail_off  = fault_pkg::RAILS_CLEAR;
      state_next.drive     = '0;
      state_next.stage_off = fault_pkg::STAGES_CLEAR;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= reset_state();
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops
  assign drive_o      = state_reg.drive;
  assign stage_off_o  = state_reg.stage_off;
  assign rail_off_o   = state_reg.rail_off;
  assign core_reset_o = !state_reg.rst_agreed;

endmodule

// >>> sim/hw_fault_pwm_shutdown_properties.sv
// Checker of the fault shutdown ports
`timescale 1ns/1ps
module hw_fault_pwm_shutdown_properties (
  // Clock and resets
  input wire logic                    ref_clk_i,
  input wire logic                    rst_i,
  input wire logic                    device_reset_n_i,
  // Inputs
  input wire logic [2:0]              phase_count_i,
  input wire fault_pkg::rail_map_type stage_rail_i,
  input wire logic [5:0]              ext_fault_in_i,
  input wire logic [5:0]              cmp_trip_i,
  input wire logic [5:0]              cs_sample_i,
  input wire logic [3:0]              rail_reenable_i,
  // Outputs
  input wire fault_pkg::drive_type    drive_o,
  input wire logic [5:0]              stage_off_o,
  input wire logic [5:0]              cs_meas_o,
  input wire logic [5:0]              cs_cmp_o,
  input wire logic                    core_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Per stage checks; peers are the stages sharing its rail
  for (genvar i = 0; i < fault_pkg::NUM_STAGES; i++) begin : g_stage
    logic [5:0] peers;
    always_comb begin
      for (int j = 0; j < 6; j++) peers[j] = stage_rail_i[j] == stage_rail_i[i];
    end
    a_pin_fault_off: assert property (
      ext_fault_in_i[i] [*3] |-> ##[0:3] !drive_o.pwm_out[i]) else $error("pin fault kept pwm");
    a_trip_first_off: assert property (
      cmp_trip_i[i] [*3] |-> ##[0:3] !drive_o.pwm_out[i]) else $error("trip kept pwm");
    a_trip_rail_off: assert property (
      cmp_trip_i[i] [*3] |-> ##[0:4] ((drive_o.pwm_out | drive_o.sync_rect_enable) & peers) == 0)
      else $error("trip left rail driven");
    a_off_latch_holds: assert property (
      stage_off_o[i] && rail_reenable_i == 0 && $past(rail_reenable_i) == 0
      && device_reset_n_i && $stable(phase_count_i) && $stable(stage_rail_i)
      |=> stage_off_o[i]) else $error("off stage released itself");
    a_off_gates_drive: assert property (
      stage_off_o[i] |-> !drive_o.pwm_out[i] && !drive_o.sync_rect_enable[i])
      else $error("off stage still driven");
  end
  a_sense_routing: assert property (
    cs_meas_o == cs_sample_i && cs_cmp_o == cs_sample_i) else $error("sense misrouted");
  a_pin_reset_hold: assert property (
    !device_reset_n_i [*6] |-> core_reset_o && drive_o == 0) else $error("pin reset ignored");
  a_pin_reset_free: assert property (
    device_reset_n_i [*6] |-> !core_reset_o) else $error("reset stuck after pin high");
endmodule
bind hw_fault_pwm_shutdown hw_fault_pwm_shutdown_properties props (.ref_clk_i, .rst_i,
  .device_reset_n_i, .phase_count_i, .stage_rail_i, .ext_fault_in_i, .cmp_trip_i, .cs_sample_i,
  .rail_reenable_i, .drive_o, .stage_off_o, .cs_meas_o, .cs_cmp_o, .core_reset_o);

// >>> sim/stage_model.sv
// Behavioural power stage: current sense and comparator trip
`timescale 1ns/1ps
module stage_model (
  // Clock and gate drive
  input  wire logic                 clk_i,
  input  wire fault_pkg::drive_type drive_i,
  // Overload ordered by the bench
  input  wire logic [5:0]           overload_i,
  // Sense and trip back to the controller
  output logic [5:0]                cs_o,
  output logic [5:0]                trip_o
);
  // Sense follows switching and trip follows overload, both a cycle late
  always @(posedge clk_i) begin
    cs_o   <= drive_i.pwm_out;
    trip_o <= overload_i;
  end
endmodule

// >>> sim/hw_fault_pwm_shutdown_test.sv
// Randomised self-checking bench for the fault shutdown path
`timescale 1ns/1ps
module hw_fault_pwm_shutdown_test;
  logic ref_clk_i, rst_i, device_reset_n_i, core_reset_o;
  logic [2:0] phase_count_i;
  fault_pkg::rail_map_type stage_rail_i;
  logic [5:0] ext_fault_in_i, cmp_trip_i, cs_sample_i, overload, stage_off_o, cs_meas_o, cs_cmp_o;
  logic [3:0] rail_reenable_i, rail_off_o;
  fault_pkg::drive_type drive_in_i, drive_o, drive_prev;
  int seed = 29, mismatches = 0, total_checks = 0, cycles = 0;
  hw_fault_pwm_shutdown dut (.ref_clk_i, .rst_i, .device_reset_n_i, .phase_count_i, .stage_rail_i,
    .ext_fault_in_i, .cmp_trip_i, .cs_sample_i, .rail_reenable_i, .drive_in_i, .drive_o,
    .stage_off_o, .rail_off_o, .cs_meas_o, .cs_cmp_o, .core_reset_o);
  stage_model partner (.clk_i(ref_clk_i), .drive_i(drive_o), .overload_i(overload),
    .cs_o(cs_sample_i), .trip_o(cmp_trip_i));
  // Clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Random raw drive, its one-cycle-late copy and the hang limit
  always @(posedge ref_clk_i) begin
    drive_in_i <= 12'($random(seed));
    drive_prev <= drive_in_i;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  function automatic logic [5:0] peers(int s);
    for (int j = 0; j < 6; j++) peers[j] = stage_rail_i[j] == stage_rail_i[s];
  endfunction
  // Pulse the re-enable of a stage's rail, then expect everything back on
  task automatic reopen(int s);
    @(posedge ref_clk_i) rail_reenable_i <= 4'h1 << stage_rail_i[s];
    @(posedge ref_clk_i) rail_reenable_i <= 4'h0;
    tick(2);
    chk("stage_off", 12'h000, 12'(stage_off_o));
    chk("drive", drive_prev, drive_o);
    chk("rail_off", 12'h000, 12'(rail_off_o));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_i = 1'b1; device_reset_n_i = 1'b1; phase_count_i = 3'h6; ext_fault_in_i = 6'h00;
    overload = 6'h00; rail_reenable_i = 4'h0;
    stage_rail_i = {2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int n = 1; n <= 6; n++) begin
      @(posedge ref_clk_i) phase_count_i <= 3'(n);
      tick(3);
      repeat (4) begin
        tick(1);
        chk("drive", drive_prev & {2{6'h3F >> (6 - n)}}, drive_o);
        chk("sense", {2{cs_sample_i}}, {cs_meas_o, cs_cmp_o});
      end
    end
    $display("test pass-through done");
    for (int s = 0; s < 6; s++) begin
      @(posedge ref_clk_i) ext_fault_in_i <= 6'h01 << s;
      tick(6);
      chk("stage_off", 12'(6'h01 << s), 12'(stage_off_o));
      @(posedge ref_clk_i) ext_fault_in_i <= 6'h00;
      tick(8);
      chk("held_off", 12'(6'h01 << s), 12'(stage_off_o));
      reopen(s);
      @(posedge ref_clk_i) overload <= 6'h01 << s;
      tick(7);
      chk("rail_stages", 12'(peers(s)), 12'(stage_off_o));
      chk("rail_drive", 12'h000, drive_o & {2{peers(s)}});
      chk("rail_off", 12'(4'h1 << stage_rail_i[s]), 12'(rail_off_o));
      @(posedge ref_clk_i) overload <= 6'h00;
      tick(6);
      reopen(s);
    end
    $display("test fault shutdown done");
    @(posedge ref_clk_i) ext_fault_in_i <= 6'h04;
    tick(6);
    @(posedge ref_clk_i) begin
      ext_fault_in_i <= 6'h00;
      device_reset_n_i <= 1'b0;
    end
    tick(7);
    chk("core_reset", 12'h800, {core_reset_o, 11'h000});
    chk("reset_drive", 12'h000, drive_o);
    chk("reset_off", 12'h000, {2'h0, rail_off_o, stage_off_o});
    @(posedge ref_clk_i) device_reset_n_i <= 1'b1;
    tick(7);
    chk("stage_off", 12'h000, {core_reset_o, 5'h00, stage_off_o});
    $display("test device reset done");
    conclude();
  end
endmodule
